// *** core/hbfm_core.v ***
// Half-bridge fault manager with Wishbone register access
// Functional notes
// - Latched faults need host reset to recover
// - Supply lockout auto-recovers, status not latched
// - Config writes accepted during lockout, applied after
// - Load supply undervoltage forces outputs off, flags
// - Supply recovery clears flag, restores outputs
// - Interface and settings retained during undervoltage
// - Writes during undervoltage apply on recovery
// - Logic undervoltage clears command and status, off
// - Power-on reset zeroes command and status
// - Underload on any enabled, unlatched channel starts shared timer
// - Later underload does not restart timer
// - Expiry with shutdown enabled latches channel off
// - Shutdown disabled keeps drivers on
// - Status reset clears underload and reactivates
// - Channel status codes off, ocs, uld, on
//
// The Wishbone slave port and the register addresses were decided locally.
`timescale 1ns/1ns
`include "hbfm_defines.vh"
module hbfm_core #(
  parameter ULD_CYCLES = `HBFM_ULD_CYCLES
) (
  // Clock and reset
  input  wire        CORE_CLK,
  input  wire        RST_N,
  // Wishbone slave
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [3:0]  WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  output reg         WB_ACK_O,
  // Supply and load monitors
  input  wire        VS1_UV,
  input  wire        VS2_UV,
  input  wire        VS_OV,
  input  wire        VCC_UV,
  input  wire [7:0]  UNDERLOAD,
  input  wire [7:0]  OVERCURRENT,
  input  wire        FRAME_START,
  // Driver outputs
  output reg  [7:0]  HB_ENABLE,
  output reg  [7:0]  HB_CONFIG,
  output wire        IRQ
);

// ----------------------------------------
// Input synchronisers
// ----------------------------------------
localparam NSYNC   = 21;
localparam SYN_VS1 = 16;
localparam SYN_VS2 = 17;
localparam SYN_OV  = 18;
localparam SYN_VCC = 19;
localparam SYN_FS  = 20;
wire [NSYNC-1:0] raw_in = {FRAME_START, VCC_UV, VS_OV,
                           VS2_UV, VS1_UV,
                           OVERCURRENT, UNDERLOAD};
reg  [NSYNC-1:0] s1_ff;
reg  [NSYNC-1:0] s2_ff;
reg  [NSYNC-1:0] s3_ff;
reg  [NSYNC-1:0] flt_ff;
genvar gi;
generate
  for (gi = 0; gi < NSYNC; gi = gi + 1)
  begin : g_sync
    always @(posedge CORE_CLK or negedge RST_N)
    begin
      if (!RST_N)
      begin
        s1_ff[gi]  <= 1'b0;
        s2_ff[gi]  <= 1'b0;
        s3_ff[gi]  <= 1'b0;
        flt_ff[gi] <= 1'b0;
      end
      else
      begin
        s1_ff[gi] <= raw_in[gi];
        s2_ff[gi] <= s1_ff[gi];
        s3_ff[gi] <= s2_ff[gi];
        if (s2_ff[gi] == s3_ff[gi])
          flt_ff[gi] <= s3_ff[gi];
      end
    end
  end
endgenerate
wire [7:0] uld_in  = flt_ff[7:0];
wire [7:0] ocs_in  = flt_ff[15:8];
wire       vs_uv   = flt_ff[SYN_VS1] | flt_ff[SYN_VS2];
wire       vs_ov   = flt_ff[SYN_OV];
wire       vcc_uv  = flt_ff[SYN_VCC];
wire       frm     = flt_ff[SYN_FS];

// ----------------------------------------
// Registers
// ----------------------------------------
reg  [15:0] cmd_ff;
reg  [15:0] status_ff;
reg  [7:0]  latch_ff;
reg  [7:0]  ocs_ff;
reg  [31:0] tmr_ff;
reg         tmr_run_ff;
reg  [2:0]  irq_sts_ff;
reg  [2:0]  irq_msk_ff;
reg         lock_d_ff;
reg         fs_d_ff;
wire        lockout = vs_uv | vs_ov;
wire        wb_req  = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
wire        wb_wr   = wb_req & WB_WE_I;
wire        cmd_wr  = wb_wr & (WB_ADR_I == `HBFM_ADR_CMD);
wire        cmd_wr_lo = cmd_wr & WB_SEL_I[0];
wire        cmd_wr_hi = cmd_wr & WB_SEL_I[1];
wire        status_reset_request     = cmd_wr_hi & WB_DAT_I[`HBFM_CMD_SRR];
wire        uld_sd  = cmd_ff[`HBFM_CMD_ULDSD];
wire [7:0]  ena     = cmd_ff[7:0];
wire        tmr_last = (tmr_ff == 32'h00000001);
wire        tmr_exp = tmr_run_ff & tmr_last;
wire [7:0]  uld_act = uld_in & ena & ~latch_ff;
wire        uld_any = (uld_act != 8'h00);
wire        drv_off = vcc_uv | lockout;

// ----------------------------------------
// Frame start edge
// ----------------------------------------
always @(posedge CORE_CLK or negedge RST_N)
begin
  if (!RST_N)
    fs_d_ff <= 1'b0;
  else
    fs_d_ff <= frm;
end
wire fs_rise = frm & ~fs_d_ff;

// ----------------------------------------
// Command register and shared timer
// ----------------------------------------
always @(posedge CORE_CLK or negedge RST_N)
begin
  if (!RST_N)
  begin
    cmd_ff     <= `HBFM_CMD_RST;
    latch_ff   <= 8'h00;
    ocs_ff     <= 8'h00;
    tmr_ff     <= 32'h00000000;
    tmr_run_ff <= 1'b0;
  end
  else if (vcc_uv)
  begin
    cmd_ff     <= `HBFM_CMD_RST;
    latch_ff   <= 8'h00;
    ocs_ff     <= 8'h00;
    tmr_ff     <= 32'h00000000;
    tmr_run_ff <= 1'b0;
  end
  else
  begin
    // Stored even during lockout
    if (cmd_wr_lo)
      cmd_ff[7:0] <= WB_DAT_I[7:0];
    if (cmd_wr_hi)
      cmd_ff[15:8] <= {1'b0, WB_DAT_I[14:8]};
    ocs_ff <= ocs_ff | (ocs_in & ena);
    if (!tmr_run_ff && uld_any)
    begin
      tmr_run_ff <= 1'b1;
      tmr_ff     <= ULD_CYCLES;
    end
    else if (tmr_run_ff)
    begin
      tmr_ff <= tmr_ff - 32'h00000001;
      if (tmr_exp)
        tmr_run_ff <= 1'b0;
    end
    if (tmr_exp && uld_sd)
      latch_ff <= latch_ff | uld_act;
    if (status_reset_request)
    begin
      latch_ff <= 8'h00;
      ocs_ff   <= 8'h00;
    end
  end
end

// ----------------------------------------
// Channel status and status word
// ----------------------------------------
reg [15:0] nxt_status;
reg [1:0]  hb_st;
integer    i;
always @*
begin
  nxt_status = 16'h0000;
  hb_st      = `HBFM_HB_OFF;
  nxt_status[`HBFM_ST_PSF] = lockout;
  nxt_status[`HBFM_ST_ULD] = |latch_ff;
  for (i = 0; i < 2; i = i + 1)
  begin
    if (ocs_ff[i])
      hb_st = `HBFM_HB_OCS;
    else if (latch_ff[i])
      hb_st = `HBFM_HB_ULD;
    else if (ena[i])
      hb_st = `HBFM_HB_ON;
    else
      hb_st = `HBFM_HB_OFF;
    nxt_status[2*i+1 +: 2] = hb_st;
  end
end
always @(posedge CORE_CLK or negedge RST_N)
begin
  if (!RST_N)
    status_ff <= `HBFM_STATUS_RST;
  else if (vcc_uv)
    status_ff <= `HBFM_STATUS_RST;
  else if (fs_rise)
    status_ff <= nxt_status;
end

// ----------------------------------------
// Driver outputs
// ----------------------------------------
always @(posedge CORE_CLK or negedge RST_N)
begin
  if (!RST_N)
  begin
    HB_ENABLE <= 8'h00;
    HB_CONFIG <= 8'h00;
    lock_d_ff <= 1'b0;
  end
  else
  begin
    lock_d_ff <= lockout;
    if (drv_off)
      HB_ENABLE <= 8'h00;
    else
      HB_ENABLE <= ena & ~latch_ff & ~ocs_ff;
    if (!drv_off)
      HB_CONFIG <= cmd_ff[15:8];
  end
end

// ----------------------------------------
// Interrupts
// ----------------------------------------
wire       ev_lock_in  = lockout & ~lock_d_ff;
wire       ev_lock_out = lock_d_ff & ~lockout;
wire       ev_uld      = tmr_exp & uld_sd & uld_any;
wire [2:0] irq_ev      = {ev_uld, ev_lock_out, ev_lock_in};
wire       sts_wr = wb_wr & (WB_ADR_I == `HBFM_ADR_IRQ_STS) & WB_SEL_I[0];
wire [2:0] sts_clr = sts_wr ? WB_DAT_I[2:0] : 3'h0;
always @(posedge CORE_CLK or negedge RST_N)
begin
  if (!RST_N)
  begin
    irq_sts_ff <= 3'h0;
    irq_msk_ff <= 3'h0;
  end
  else
  begin
    irq_sts_ff <= (irq_sts_ff & ~sts_clr) | irq_ev;
    if (wb_wr && WB_ADR_I == `HBFM_ADR_IRQ_MSK && WB_SEL_I[0])
      irq_msk_ff <= WB_DAT_I[2:0];
  end
end
assign IRQ = |(irq_sts_ff & irq_msk_ff);

// ----------------------------------------
// Wishbone read and acknowledge
// ----------------------------------------
always @(posedge CORE_CLK or negedge RST_N)
begin
  if (!RST_N)
  begin
    WB_ACK_O <= 1'b0;
    WB_DAT_O <= 32'h00000000;
  end
  else
  begin
    WB_ACK_O <= wb_req;
    if (wb_req && !WB_WE_I)
    begin
      if (WB_ADR_I == `HBFM_ADR_CMD)
        WB_DAT_O <= {16'h0000, cmd_ff};
      else if (WB_ADR_I == `HBFM_ADR_STATUS)
        WB_DAT_O <= {16'h0000, status_ff};
      else if (WB_ADR_I == `HBFM_ADR_IRQ_STS)
        WB_DAT_O <= {29'h00000000, irq_sts_ff};
      else if (WB_ADR_I == `HBFM_ADR_IRQ_MSK)
        WB_DAT_O <= {29'h00000000, irq_msk_ff};
      else if (WB_ADR_I == `HBFM_ADR_LIVE)
        WB_DAT_O <= {16'h0000, nxt_status};
      else
        WB_DAT_O <= 32'h00000000;
    end
  end
end

endmodule // hbfm_core

// *** core/hbfm_defines.vh ***
// Register offsets, field positions, reset values and timing counts
`ifndef HBFM_DEFINES_VH
`define HBFM_DEFINES_VH
// Register word addresses
`define HBFM_ADR_CMD      4'h0
`define HBFM_ADR_STATUS   4'h1
`define HBFM_ADR_IRQ_STS  4'h2
`define HBFM_ADR_IRQ_MSK  4'h3
`define HBFM_ADR_DELAY    4'h4
`define HBFM_ADR_LIVE     4'h5
// Command word fields
`define HBFM_CMD_SRR      15
`define HBFM_CMD_ULDSD    13
`define HBFM_CMD_ENA_LO   0
`define HBFM_CMD_CFG_LO   8
// Status word fields
`define HBFM_ST_PSF       14
`define HBFM_ST_ULD       13
// Channel status codes
`define HBFM_HB_OFF       2'h0
`define HBFM_HB_OCS       2'h1
`define HBFM_HB_ULD       2'h2
`define HBFM_HB_ON        2'h3
// Interrupt bits
`define HBFM_IRQ_PSF_SET  0
`define HBFM_IRQ_PSF_CLR  1
`define HBFM_IRQ_ULD      2
// Reset values
`define HBFM_CMD_RST      16'h0000
`define HBFM_STATUS_RST   16'h0000
// Underload delay in microseconds and as cycles at 50 MHz
`define HBFM_ULD_DELAY_US 200
`define HBFM_CLK_MHZ      50
`define HBFM_ULD_CYCLES   (`HBFM_ULD_DELAY_US * `HBFM_CLK_MHZ)
`endif

// *** tb/hbfm_host.sv ***
// Host bus master model issuing register cycles
`timescale 1ns/1ns
module hbfm_host (
  // Clock
  input  logic        clk,
  // Wishbone master
  output logic        cyc,
  output logic        stb,
  output logic        we,
  output logic [3:0]  adr,
  output logic [3:0]  sel,
  output logic [31:0] dat,
  input  logic [31:0] din,
  input  logic        ack
);
  initial {cyc, stb, we, adr, sel, dat} = '0;
  // ------------------------------
  // One cycle, entered at an edge
  // ------------------------------
  task automatic xfer(input logic w, input logic [3:0] a,
    input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = din;
    cyc <= 1'b0;
    stb <= 1'b0;
    adr <= ~a;
    dat <= ~d;
    @(posedge clk);
  endtask
endmodule // hbfm_host

// *** tb/hbfm_core_chk.sv ***
// Checker for handshake and shutdown relations
`timescale 1ns/1ns
module hbfm_core_chk #(
  parameter ULD_CYCLES = 20
) (
  // Clock and reset
  input logic       CORE_CLK,
  input logic       RST_N,
  // Bus and monitors
  input logic       WB_CYC_I,
  input logic       WB_STB_I,
  input logic       WB_ACK_O,
  input logic       VS1_UV,
  input logic       VS2_UV,
  input logic       VS_OV,
  input logic       VCC_UV,
  input logic [7:0] OVERCURRENT,
  input logic [7:0] UNDERLOAD,
  // Outputs
  input logic [7:0] HB_ENABLE,
  input logic       IRQ
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  a_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
    |=> WB_ACK_O) else $error("ack late");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  a_ack_cause: assert property ($rose(WB_ACK_O)
    |-> $past(WB_CYC_I && WB_STB_I)) else $error("ack unasked");
  a_vcc_off: assert property (VCC_UV[*6] |-> HB_ENABLE == 8'h00)
    else $error("on in logic undervoltage");
  a_vs_uv_off: assert property ((VS1_UV || VS2_UV)[*6]
    |-> HB_ENABLE == 8'h00) else $error("on in undervoltage");
  a_ov_off: assert property (VS_OV[*6] |-> HB_ENABLE == 8'h00)
    else $error("on in overvoltage");
  a_oc_off: assert property (OVERCURRENT[0][*7] |-> !HB_ENABLE[0])
    else $error("on in overcurrent");
  a_rst_zero: assert property ($rose(RST_N) |-> !HB_ENABLE && !IRQ)
    else $error("outputs after reset");
  c_ack: cover property (WB_ACK_O ##2 WB_ACK_O);
  c_uv: cover property (VS1_UV ##8 HB_ENABLE == 8'h00);
  c_uld: cover property ($fell(HB_ENABLE[0]) && UNDERLOAD[0]);
endmodule // hbfm_core_chk
bind hbfm_core hbfm_core_chk #(.ULD_CYCLES(ULD_CYCLES)) hbfm_core_chk_inst (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .VS1_UV(VS1_UV),
  .VS2_UV(VS2_UV), .VS_OV(VS_OV), .VCC_UV(VCC_UV),
  .OVERCURRENT(OVERCURRENT), .UNDERLOAD(UNDERLOAD),
  .HB_ENABLE(HB_ENABLE), .IRQ(IRQ));

// *** tb/hbfm_core_tb_top.sv ***
// Self-checking bench for the fault manager
`timescale 1ns/1ns
module hbfm_core_tb_top;
  localparam int UNDERLOAD_FLAG = 20;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        vs1 = 1'b0, vs2 = 1'b0, ov = 1'b0, vcc = 1'b0, frm = 1'b0;
  logic [7:0]  underload_flag = 8'h00, oc = 8'h00, en, cfg, r;
  logic        cyc, stb, we, ack, irq;
  logic [3:0]  adr, sel;
  logic [31:0] dw, dr, q;
  int          error_cnt = 0, num_checks = 0, seed = 60;
  always #10 clk = ~clk;
  hbfm_host hbfm_host_inst (.clk(clk), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .dat(dw), .din(dr), .ack(ack));
  hbfm_core #(.ULD_CYCLES(UNDERLOAD_FLAG)) hbfm_core_inst (.CORE_CLK(clk),
    .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dw), .WB_DAT_O(dr),
    .WB_ACK_O(ack), .VS1_UV(vs1), .VS2_UV(vs2), .VS_OV(ov),
    .VCC_UV(vcc), .UNDERLOAD(underload_flag), .OVERCURRENT(oc), .FRAME_START(frm),
    .HB_ENABLE(en), .HB_CONFIG(cfg), .IRQ(irq));
  // ------------------------------
  // Helpers
  // ------------------------------
  function automatic logic [7:0] en_exp(input logic [7:0] c,
    input logic off, input logic [7:0] lat);
    return off ? 8'h00 : (c & ~lat);
  endfunction
  task automatic chk(input string n, input logic [31:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    hbfm_host_inst.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a);
    hbfm_host_inst.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic snap;
    frm <= 1'b1;
    wt(5);
    frm <= 1'b0;
    rd(4'h1);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    wt(20000);
    error_cnt++;
    conclude();
  end
  // ------------------------------
  // Scenarios
  // ------------------------------
  initial
  begin
    wt(4);
    rst_n <= 1'b1;
    wt(1);
    rd(4'h0);
    chk("cmd_rst", 32'h0, q);
    rd(4'h1);
    chk("sts_rst", 32'h0, q);
    rd(4'h7);
    chk("unmapped", 32'h0, q);
    repeat (4)
    begin
      r = 8'($random(seed));
      wr(4'h0, {24'h0, r});
      wt(2);
      chk("en_rand", en_exp(r, 1'b0, 8'h00), en);
    end
    wr(4'h3, 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      wr(4'h0, 32'h0F);
      {ov, vs2, vs1} <= 3'b001 << i;
      wt(8);
      chk("en_lock", en_exp(8'h0F, 1'b1, 8'h00), en);
      chk("irq_set", 1'b1, irq);
      wr(4'h0, 32'h04F0);
      chk("en_held", 8'h00, en);
      chk("cfg_held", 8'h00, cfg);
      snap();
      chk("fail_set", 1'b1, q[14]);
      wr(4'h2, 32'h1);
      chk("irq_clr", 1'b0, irq);
      {ov, vs2, vs1} <= 3'b000;
      wt(8);
      chk("en_back", 8'hF0, en);
      chk("cfg_back", 8'h04, cfg);
      chk("irq_mask", 1'b0, irq);
      snap();
      chk("fail_clr", 1'b0, q[14]);
    end
    wr(4'h2, 32'h7);
    wr(4'h0, 32'h20FF);
    underload_flag <= 8'h01;
    wt(UNDERLOAD_FLAG / 2);
    underload_flag <= 8'h03;
    wt(UNDERLOAD_FLAG / 2 + 8);
    chk("en_uld", en_exp(8'hFF, 1'b0, 8'h03), en);
    snap();
    chk("uld_set", 5'h1A, {q[13], q[4:1]});
    underload_flag <= 8'h00;
    wt(8);
    chk("en_stay", 8'hFC, en);
    wr(4'h0, 32'hE0FF);
    wt(2);
    chk("en_srr", 8'hFF, en);
    snap();
    chk("uld_clr", 5'h0F, {q[13], q[4:1]});
    wr(4'h0, 32'h00FF);
    underload_flag <= 8'h80;
    wt(UNDERLOAD_FLAG + 10);
    chk("en_keep", 8'hFF, en);
    underload_flag <= 8'h00;
    oc <= 8'h01;
    wt(8);
    chk("en_oc", 8'hFE, en);
    oc <= 8'h00;
    rst_n <= 1'b0;
    wt(2);
    rst_n <= 1'b1;
    wt(1);
    chk("en_rst2", 8'h00, en);
    wr(4'h0, 32'hFF);
    vcc <= 1'b1;
    wt(8);
    chk("en_vcc", 8'h00, en);
    vcc <= 1'b0;
    wt(8);
    rd(4'h0);
    chk("cmd_vcc", 32'h0, q);
    rd(4'h1);
    chk("sts_vcc", 32'h0, q);
    conclude();
  end
endmodule // hbfm_core_tb_top
